// ===== slot_ctrl_cfg.svh
/*
 * Offsets, field positions, reset values and fixed codes of the dual card slot
 * control register bank.
 * Assumes it is included by its bare name from the package and the design files.
 */
`ifndef SLOT_CTRL_CFG_SVH
`define SLOT_CTRL_CFG_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_HARDWARE_IDENTITY 8'h00
`define OFS_DRIVER_REVISION 8'h01
`define OFS_SLOT_STATUS 8'h04
`define OFS_SLOT_CONTROL 8'h08

// ****************************************************************
// Control register fields
// ****************************************************************
`define CTL_ONE_ENABLE 0
`define CTL_ONE_LEVEL 1
`define CTL_ONE_STATE_LO 2
`define CTL_TWO_ENABLE 4
`define CTL_TWO_LEVEL 5
`define CTL_TWO_STATE_LO 6

// ****************************************************************
// Status register fields
// ****************************************************************
`define STA_ONE_LO 4
`define STA_TWO_LO 6

// ****************************************************************
// Reset and fixed values
// ****************************************************************
`define SLOT_CONTROL_RESET 8'h00
`define DRIVER_REVISION_VALUE 8'h00
// Identity nibbles: arbitrary values, not those of any real part
`define MAKER_ID_DEFAULT 4'hA
`define HW_REV_DEFAULT 4'h3
`define UNMAPPED_READ 8'h00

`endif

// ===== slot_ctrl_pkg.sv
/*
 * Types of the dual card slot control register bank.
 * Assumes slot_ctrl_cfg.svh is on the include path.
 */
package slot_ctrl_pkg;
    `include "slot_ctrl_cfg.svh"

    // Interface condition codes shared by state and status fields
    typedef enum logic [1:0] {
        COND_DOWN = 2'h0,
        COND_ISOLATED = 2'h1,
        COND_POWERED = 2'h2,
        COND_ACTIVE = 2'h3
    } cond_t;

    // Voltage level selection
    typedef enum logic {
        LEVEL_1V8 = 1'h0,
        LEVEL_2V95 = 1'h1
    } level_t;
endpackage

// ===== slot_condition.sv
/*
 * Per-slot condition logic: folds the stored state field and the supply
 * enable into the reported condition, and drives the slot's supply controls.
 * Assumes it is fed from registers of the same clock domain.
 */
`timescale 1ns/100ps
module slot_condition
    import slot_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Stored control fields
    input wire logic [1:0] stateField,
    input wire logic supplyEnable,
    input wire logic supplyLevel,
    // Reported condition and supply controls
    output logic [1:0] condition,
    output logic supplyOn,
    output logic supplyPullDown,
    output logic supplyHigh,
    output logic cardPullDown
);
    // ****************************************************************
    // Next values
    // ****************************************************************
    logic [1:0] condition_nxt; // Reported condition
    logic [1:0] condition_r;
    logic supplyOn_r; // Regulator running
    logic supplyHigh_r; // 2.95 V selected
    logic cardPullDown_r; // Card side pull-downs active

    // Condition folding and supply control
    always_comb begin
        // Down state with regulator on reads as powered
        if (stateField == COND_DOWN && supplyEnable) begin
            condition_nxt = COND_POWERED;
        end else begin
            condition_nxt = stateField;
        end
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            condition_r <= 2'h0;
            supplyOn_r <= 1'b0;
            supplyHigh_r <= 1'b0;
            cardPullDown_r <= 1'b1;
        end else begin
            condition_r <= condition_nxt;
            supplyOn_r <= supplyEnable;
            supplyHigh_r <= supplyLevel;
            // Pull-downs active in codes 00 and 10
            cardPullDown_r <= ~condition_nxt[0];
        end
    end

    assign condition = condition_r;
    assign supplyOn = supplyOn_r;
    assign supplyPullDown = ~supplyOn_r;
    assign supplyHigh = supplyHigh_r;
    assign cardPullDown = cardPullDown_r;
endmodule // slot_condition

// ===== slot_ctrl_regs.sv
/*
 * Register bank of a dual card slot multiplexer: identity, driver revision,
 * slot status and slot control, reached through a simple byte-wide register
 * port served by the two-wire serial front end.
 * Assumes regAddr, regWrite, regRead and regWdata come from logic on clk, and
 * that the serial front end and analog supplies sit outside.
 */
// Function
// - Read-only identity register at offset 00
// - Upper nibble holds fixed maker code
// - Read-only driver revision at 01, zero
// - Status bits 5:4 report slot one
// - Status bits 7:6 report slot two
// - Status from state bits and supply enable
// - Bit 0 enables slot one supply
// - Bit 1 selects slot one level
// - Bits 3:2 set slot one state
// - Bit 4 enables slot two supply
// - Control register resets to zero
// - State code 10 is stored unblocked
// - Code 10 leaves supply enable alone
// - Supply enables never alter state bits
// - Bit 5 level, bits 7:6 slot two
// - Reset disables supplies, pulls signals low
`timescale 1ns/100ps
module slot_ctrl_regs
    import slot_ctrl_pkg::*;
#(
    parameter logic [3:0] MAKER_ID = `MAKER_ID_DEFAULT, // Arbitrary value
    parameter logic [3:0] HW_REV = `HW_REV_DEFAULT // Arbitrary value
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    output logic regRvalid,
    // Slot one supply and card side
    output logic slotOneSupplyOn,
    output logic slotOneSupplyPullDown,
    output logic slotOneSupplyHigh,
    output logic slotOneCardPullDown,
    // Slot two supply and card side
    output logic slotTwoSupplyOn,
    output logic slotTwoSupplyPullDown,
    output logic slotTwoSupplyHigh,
    output logic slotTwoCardPullDown
);
    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Extracts a two bit field at a given low bit
    function automatic logic [1:0] field2(input logic [7:0] v, input int lo);
        field2 = v[lo +: 2];
    endfunction

    // ****************************************************************
    // Control register
    // ****************************************************************
    logic [7:0] slotControl_r; // Stored control byte
    logic [7:0] slotControl_nxt;
    logic [1:0] slotOneCondition; // Reported slot one condition
    logic [1:0] slotTwoCondition; // Reported slot two condition

    // Write decode: every code is stored as written
    always_comb begin
        slotControl_nxt = slotControl_r;
        if (regWrite && regAddr == `OFS_SLOT_CONTROL) begin
            slotControl_nxt = regWdata;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            slotControl_r <= `SLOT_CONTROL_RESET;
        end else begin
            slotControl_r <= slotControl_nxt;
        end
    end

    // ****************************************************************
    // Slot condition instances
    // ****************************************************************
    slot_condition slotOne (
        .clk(clk),
        .arst_n(arst_n),
        .stateField(field2(slotControl_r, `CTL_ONE_STATE_LO)),
        .supplyEnable(slotControl_r[`CTL_ONE_ENABLE]),
        .supplyLevel(slotControl_r[`CTL_ONE_LEVEL]),
        .condition(slotOneCondition),
        .supplyOn(slotOneSupplyOn),
        .supplyPullDown(slotOneSupplyPullDown),
        .supplyHigh(slotOneSupplyHigh),
        .cardPullDown(slotOneCardPullDown)
    );

    slot_condition slotTwo (
        .clk(clk),
        .arst_n(arst_n),
        .stateField(field2(slotControl_r, `CTL_TWO_STATE_LO)),
        .supplyEnable(slotControl_r[`CTL_TWO_ENABLE]),
        .supplyLevel(slotControl_r[`CTL_TWO_LEVEL]),
        .condition(slotTwoCondition),
        .supplyOn(slotTwoSupplyOn),
        .supplyPullDown(slotTwoSupplyPullDown),
        .supplyHigh(slotTwoSupplyHigh),
        .cardPullDown(slotTwoCardPullDown)
    );

    // ****************************************************************
    // Read path
    // ****************************************************************
    logic [7:0] slotStatus; // Status byte, low nibble unused
    logic [7:0] regRdata_r;
    logic [7:0] regRdata_nxt;
    logic regRvalid_r;
    logic regRvalid_nxt;

    // Status assembly
    always_comb begin
        slotStatus = 8'h00;
        slotStatus[`STA_ONE_LO +: 2] = slotOneCondition;
        slotStatus[`STA_TWO_LO +: 2] = slotTwoCondition;
    end

    // Read decode; unmapped offsets read zero
    always_comb begin
        regRvalid_nxt = regRead;
        regRdata_nxt = regRdata_r;
        if (regRead) begin
            unique case (regAddr)
                `OFS_HARDWARE_IDENTITY: begin
                    regRdata_nxt = {MAKER_ID, HW_REV};
                end
                `OFS_DRIVER_REVISION: begin
                    regRdata_nxt = `DRIVER_REVISION_VALUE;
                end
                `OFS_SLOT_STATUS: begin
                    regRdata_nxt = slotStatus;
                end
                `OFS_SLOT_CONTROL: begin
                    regRdata_nxt = slotControl_r;
                end
                default: begin
                    regRdata_nxt = `UNMAPPED_READ;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            regRdata_r <= 8'h00;
            regRvalid_r <= 1'b0;
        end else begin
            regRdata_r <= regRdata_nxt;
            regRvalid_r <= regRvalid_nxt;
        end
    end

    assign regRdata = regRdata_r;
    assign regRvalid = regRvalid_r;
endmodule // slot_ctrl_regs

// ===== slot_ctrl_regs_chk.sv
/* Port checker of the slot register bank.
   Assumes binding into slot_ctrl_regs on one clock. */
`timescale 1ns/100ps
`include "slot_ctrl_cfg.svh"
module slot_ctrl_regs_chk
    import slot_ctrl_pkg::*;
#(
    parameter logic [3:0] MAKER_ID = `MAKER_ID_DEFAULT, // Arbitrary value
    parameter logic [3:0] HW_REV = `HW_REV_DEFAULT // Arbitrary value
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic regRvalid,
    // Slot outputs
    input wire logic slotOneSupplyOn,
    input wire logic slotOneSupplyPullDown,
    input wire logic slotOneSupplyHigh,
    input wire logic slotOneCardPullDown,
    input wire logic slotTwoSupplyOn,
    input wire logic slotTwoSupplyPullDown,
    input wire logic slotTwoSupplyHigh,
    input wire logic slotTwoCardPullDown
);
    // ****
    // Properties
    // ****
    logic ctlHit; // Write to the control byte
    assign ctlHit = regWrite && regAddr == 8'h08;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    a_read_answer: assert property (regRead |=> regRvalid) else $error("read not answered");
    a_ident_read: assert property (regRead && regAddr == 8'h00 |=> regRdata == {MAKER_ID, HW_REV})
        else $error("identity wrong");
    a_rev_zero: assert property (regRead && regAddr == 8'h01 |=> regRdata == 8'h00)
        else $error("revision not zero");
    a_stat_unused: assert property (regRead && regAddr == 8'h04 |=> regRdata[3:0] == 4'h0)
        else $error("status low bits set");
    a_one_pull: assert property (slotOneSupplyPullDown != slotOneSupplyOn) else $error("pull one");
    a_two_pull: assert property (slotTwoSupplyPullDown != slotTwoSupplyOn) else $error("pull two");
    a_one_follow: assert property (ctlHit ##1 !ctlHit |=> {slotOneSupplyHigh, slotOneSupplyOn} ==
        $past(regWdata[1:0], 2) && slotOneCardPullDown != $past(regWdata[2], 2)) else $error("slot one");
    a_two_follow: assert property (ctlHit ##1 !ctlHit |=> {slotTwoSupplyOn, slotTwoSupplyHigh} ==
        {$past(regWdata[4], 2), $past(regWdata[5], 2)} && slotTwoCardPullDown != $past(regWdata[6], 2))
        else $error("slot two");
    a_reset_off: assert property ($rose(arst_n) |-> !slotOneSupplyOn && !slotTwoSupplyOn
        && !slotOneSupplyHigh && !slotTwoSupplyHigh && slotOneCardPullDown && slotTwoCardPullDown)
        else $error("reset state");
    c_ident: cover property (regRead && regAddr == 8'h00);
    c_code_ten: cover property (ctlHit && regWdata[3:2] == 2'h2);
    c_status: cover property (regRead && regAddr == 8'h04);
endmodule // slot_ctrl_regs_chk
bind slot_ctrl_regs slot_ctrl_regs_chk #(.MAKER_ID(MAKER_ID), .HW_REV(HW_REV)) i_chk (.clk, .arst_n,
    .regAddr, .regWrite, .regRead, .regWdata, .regRdata, .regRvalid, .slotOneSupplyOn,
    .slotOneSupplyPullDown, .slotOneSupplyHigh, .slotOneCardPullDown, .slotTwoSupplyOn,
    .slotTwoSupplyPullDown, .slotTwoSupplyHigh, .slotTwoCardPullDown);

// ===== slot_host_model.sv
/* Host that drives the register port.
   Assumes the caller waits for reset release. */
`timescale 1ns/100ps
module slot_host_model (
    // Clock
    input wire logic clk,
    // Register port requests
    output logic [7:0] regAddr,
    output logic regWrite,
    output logic regRead,
    output logic [7:0] regWdata
);
    // Idle bus at time zero
    initial begin
        {regAddr, regWrite, regRead, regWdata} = 18'h0;
    end
    // One write pulse; released lines show the inverse
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        regAddr <= ~a;
        regWdata <= ~d;
    endtask
    // One read pulse
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        regAddr <= ~a;
    endtask
endmodule // slot_host_model

// ===== dual_card_slot_control_registers_tb_top.sv
/* Self-checking bench of the slot register bank.
   Assumes the host model and the bound checker. */
`timescale 1ns/100ps
`include "slot_ctrl_cfg.svh"
module dual_card_slot_control_registers_tb_top
    import slot_ctrl_pkg::*;
;
    logic clk = 1'b0, arst_n = 1'b0;
    wire logic [7:0] regAddr, regWdata;
    wire logic regWrite, regRead;
    logic [7:0] regRdata, ctl = 8'h00; // Expected control byte
    logic regRvalid;
    logic [7:0] o; // Slot outputs
    logic [7:0] q[$]; // Expected read data
    logic [7:0] firstAddrs [5] = '{8'h00, 8'h01, 8'h04, 8'h08, 8'h02}; // Offsets of the opening reads
    int fails = 0, samplesChecked = 0, cycles = 0;
    logic [31:0] r;
    always #10 clk = ~clk;
    slot_host_model i_host (.clk(clk), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
        .regWdata(regWdata));
    slot_ctrl_regs i_dut (.clk(clk), .arst_n(arst_n), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
        .slotOneSupplyOn(o[7]), .slotOneSupplyPullDown(o[6]), .slotOneSupplyHigh(o[5]),
        .slotOneCardPullDown(o[4]), .slotTwoSupplyOn(o[3]), .slotTwoSupplyPullDown(o[2]),
        .slotTwoSupplyHigh(o[1]), .slotTwoCardPullDown(o[0]));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        samplesChecked++;
        if (s !== e) begin
            fails++;
            $display("Error at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic close_out();
        // A read that was never answered leaves its note behind
        if (q.size() != 0) fails++;
        $display("checks %0d mismatches %0d", samplesChecked, fails);
        if (fails == 0 && samplesChecked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic [1:0] cnd(input logic [1:0] s, input logic e);
        return (s == 2'h0 && e) ? 2'h2 : s;
    endfunction
    // Note the expected answer, then read
    task automatic rq(input logic [7:0] a);
        case (a)
            8'h00: q.push_back({`MAKER_ID_DEFAULT, `HW_REV_DEFAULT});
            8'h04: q.push_back({cnd(ctl[7:6], ctl[4]), cnd(ctl[3:2], ctl[0]), 4'h0});
            8'h08: q.push_back(ctl);
            default: q.push_back(8'h00);
        endcase
        i_host.rd(a);
    endtask
    task automatic chk_out();
        @(posedge clk);
        #1 chk(o, {ctl[0], !ctl[0], ctl[1], !ctl[2], ctl[4], !ctl[4], ctl[5], !ctl[6]});
    endtask
    task automatic wc(input logic [7:0] d);
        i_host.wr(8'h08, d);
        ctl = d;
        chk_out();
    endtask
    // Read results against the oldest note
    always @(posedge clk) begin
        if (regRvalid === 1'b1) chk(regRdata, q.size() ? q.pop_front() : 8'hXX);
    end
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            close_out();
        end
    end
    initial begin
        r = $urandom(32'hFE7F);
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        chk_out();
        for (int k = 0; k < 5; k++) rq(firstAddrs[k]);
        i_host.wr(8'h00, 8'h55);
        i_host.wr(8'h04, 8'hFF);
        rq(8'h00);
        rq(8'h04);
        $display("test reset and read-only done");
        for (int i = 0; i < 32; i++) begin
            r = $urandom;
            wc({i[4:3], r[1], i[2] ^ i[0], i[1:0], r[0], i[2]});
            rq(8'h04);
            rq(8'h08);
        end
        $display("test all codes done");
        wc(8'hFF);
        @(posedge clk) arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        ctl = 8'h00;
        chk_out();
        rq(8'h08);
        rq(8'h04);
        repeat (4) @(posedge clk);
        $display("test mid-run reset done");
        close_out();
    end
endmodule // dual_card_slot_control_registers_tb_top
